// ### dv/dpmr_tpu_model.sv
// Fetch sequencer standing in for one time processor unit read port.
`timescale 1ns/100ps
module dpmr_tpu_model #(
    parameter int unsigned AW = 4
) (
    // Clock and control
    input wire logic clk,
    input wire logic run,
    input wire logic [AW-1:0] base,
    // Fetch request
    output logic req,
    output logic [AW-1:0] addr
);
    logic [AW-1:0] cnt_ff;
    initial begin
        req = 1'h0;
        addr = '0;
        cnt_ff = '0;
    end
    // An idle port scrambles its index so that a stale address never passes for a live one.
    always @(posedge clk) begin
        req <= run;
        addr <= run ? base + cnt_ff : ~addr;
        cnt_ff <= run ? cnt_ff + 1'h1 : '0;
    end
endmodule // dpmr_tpu_model

// ### dv/testbench.sv
// Self-checking testbench for the dual-port microcode RAM.
`timescale 1ns/100ps
module testbench;
    import dpmr_pkg::*;
    localparam int unsigned AW = 4;
    logic clk = 1'h0, reset = 1'h1, bus_req = 1'h0, bus_ctrl_sel = 1'h0, bus_array_sel = 1'h0;
    logic bus_wr = 1'h0, bus_super = 1'h0, ucode_mode = 1'h0, run_a = 1'h0, run_b = 1'h0;
    logic [1:0] bus_size = 2'h0;
    logic [AW+1:0] bus_addr = '0;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, tpu_a_data, tpu_b_data;
    logic bus_ack, bus_err, tpu_a_req, tpu_b_req;
    logic [AW-1:0] tpu_a_addr, tpu_b_addr, base_a = '0, base_b = '0;
    logic [31:0] shadow [16];
    logic [31:0] rd, s1, s2, s3;
    int fail_count = 0, total_checks = 0, cycles = 0;

    always #2 clk = ~clk;

    dpmr_top #(.DEPTH(16), .AW(AW)) dut (.clk(clk), .reset(reset), .bus_req(bus_req),
        .bus_ctrl_sel(bus_ctrl_sel), .bus_array_sel(bus_array_sel), .bus_wr(bus_wr), .bus_super(bus_super),
        .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_err(bus_err), .ucode_mode(ucode_mode), .tpu_a_req(tpu_a_req),
        .tpu_a_addr(tpu_a_addr), .tpu_a_data(tpu_a_data), .tpu_b_req(tpu_b_req), .tpu_b_addr(tpu_b_addr),
        .tpu_b_data(tpu_b_data));
    dpmr_tpu_model #(.AW(AW)) port_a (.clk(clk), .run(run_a), .base(base_a), .req(tpu_a_req), .addr(tpu_a_addr));
    dpmr_tpu_model #(.AW(AW)) port_b (.clk(clk), .run(run_b), .base(base_b), .req(tpu_b_req), .addr(tpu_b_addr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One complete bus cycle; the request stands until the answer is sampled.
    task automatic bus(input logic ctrl, input logic wr, input logic sup, input logic [1:0] size,
                       input logic [AW+1:0] addr, input logic [31:0] wd, input logic exp_err,
                       output logic [31:0] rdo);
        int n;
        n = 0;
        @(posedge clk);
        bus_req <= 1'h1;
        bus_ctrl_sel <= ctrl;
        bus_array_sel <= ~ctrl;
        bus_wr <= wr;
        bus_super <= sup;
        bus_size <= size;
        bus_addr <= addr;
        bus_wdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (bus_ack !== 1'h1 && bus_err !== 1'h1 && n < 60);
        rdo = bus_rdata;
        check({31'h0, bus_ack || bus_err}, 32'h1);
        check({31'h0, bus_err}, {31'h0, exp_err});
        bus_req <= 1'h0;
        bus_ctrl_sel <= 1'h0;
        bus_array_sel <= 1'h0;
    endtask

    task automatic t_reset;
        check({30'h0, bus_ack, bus_err}, 32'h0);
        check(bus_rdata, 32'h0);
        check(tpu_a_data, 32'h0);
        check(tpu_b_data, 32'h0);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_CONFIG, 32'h0, 1'h0, rd);
        check(rd, RST_CONFIG);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_BASE, 32'h0, 1'h0, rd);
        check(rd, RST_BASE);
    endtask

    task automatic t_ctrl;
        bus(1'h1, 1'h0, 1'h0, SIZE_WORD, OFF_CONFIG, 32'h0, 1'h1, rd);
        bus(1'h1, 1'h1, 1'h0, SIZE_WORD, OFF_BASE, 32'hFFFF_FFFF, 1'h1, rd);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_BASE, 32'h0, 1'h0, rd);
        check(rd, RST_BASE);
        bus(1'h1, 1'h1, 1'h1, SIZE_WORD, OFF_BASE, 32'hFFFF_FFFF, 1'h0, rd);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_BASE, 32'h0, 1'h0, rd);
        check(rd, MASK_BASE);
        bus(1'h1, 1'h1, 1'h1, SIZE_WORD, OFF_CONFIG, 32'hFFFF_FFFF, 1'h0, rd);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_CONFIG, 32'h0, 1'h0, rd);
        check(rd, MASK_CONFIG);
        bus(1'h1, 1'h1, 1'h1, SIZE_BYTE, 6'h20, 32'hFFFF_FFFF, 1'h0, rd);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, 6'h20, 32'h0, 1'h0, rd);
        check(rd, 32'h0);
        bus(1'h1, 1'h0, 1'h1, SIZE_HALF, 6'h3E, 32'h0, 1'h0, rd);
        check(rd, 32'h0);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, 6'h3C, 32'h0, 1'h0, rd);
        check(rd, 32'h0);
    endtask

    task automatic t_array;
        bus(1'h0, 1'h0, 1'h1, SIZE_WORD, 6'h00, 32'h0, 1'h1, rd);
        ucode_mode <= 1'h1;
        bus(1'h0, 1'h1, 1'h1, SIZE_WORD, 6'h00, 32'h5A5A_0000, 1'h0, rd);
        bus(1'h1, 1'h1, 1'h1, SIZE_WORD, OFF_TEST_CTRL, 32'h1, 1'h0, rd);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_TEST_CTRL, 32'h0, 1'h0, rd);
        check(rd, 32'h0);
        ucode_mode <= 1'h0;
        bus(1'h1, 1'h1, 1'h1, SIZE_WORD, OFF_CONFIG, 32'h0, 1'h0, rd);
        for (int i = 0; i < 16; i++) begin
            shadow[i] = 32'h1111_1111 * i + 32'h0F0F_0000;
            bus(1'h0, 1'h1, 1'h1, SIZE_WORD, {i[3:0], 2'h0}, shadow[i], 1'h0, rd);
        end
        bus(1'h0, 1'h1, 1'h1, SIZE_BYTE, {4'h3, 2'h2}, 32'h00AB_0000, 1'h0, rd);
        shadow[3][23:16] = 8'hAB;
        bus(1'h0, 1'h1, 1'h1, SIZE_HALF, {4'h4, 2'h2}, 32'h1234_0000, 1'h0, rd);
        shadow[4][31:16] = 16'h1234;
        bus(1'h0, 1'h1, 1'h1, SIZE_BYTE, {4'h3, 2'h0}, 32'h0000_00CD, 1'h0, rd);
        shadow[3][7:0] = 8'hCD;
        bus(1'h0, 1'h0, 1'h1, SIZE_BYTE, {4'h3, 2'h2}, 32'h0, 1'h0, rd);
        check(rd, 32'h0000_00AB);
        bus(1'h0, 1'h0, 1'h1, SIZE_HALF, {4'h4, 2'h2}, 32'h0, 1'h0, rd);
        check(rd, 32'h0000_1234);
        bus(1'h0, 1'h0, 1'h1, SIZE_WORD, {4'h3, 2'h0}, 32'h0, 1'h0, rd);
        check(rd, shadow[3]);
    endtask

    // Both ports fetch every cycle while a bus write to the array is held off.
    task automatic t_fetch;
        logic pra, prb;
        logic [AW-1:0] aa, ab;
        pra = 1'h0;
        prb = 1'h0;
        run_a <= 1'h1;
        run_b <= 1'h1;
        base_b <= 4'h8;
        fork
            bus(1'h0, 1'h1, 1'h1, SIZE_WORD, {4'h7, 2'h0}, 32'hCAFE_0007, 1'h0, rd);
            begin
                repeat (24) begin
                    @(posedge clk);
                    if (pra) check(tpu_a_data, shadow[aa]);
                    if (prb) check(tpu_b_data, shadow[ab]);
                    check({31'h0, bus_ack}, 32'h0);
                    pra = tpu_a_req;
                    prb = tpu_b_req;
                    aa = tpu_a_addr;
                    ab = tpu_b_addr;
                end
                run_a <= 1'h0;
                run_b <= 1'h0;
            end
        join
        shadow[7] = 32'hCAFE_0007;
        bus(1'h0, 1'h0, 1'h1, SIZE_WORD, {4'h7, 2'h0}, 32'h0, 1'h0, rd);
        check(rd, shadow[7]);
    endtask

    task automatic scan(output logic [31:0] s);
        logic [31:0] hi;
        int k;
        k = 0;
        bus(1'h1, 1'h1, 1'h1, SIZE_WORD, OFF_TEST_CTRL, 32'h1, 1'h0, rd);
        do begin
            bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_TEST_CTRL, 32'h0, 1'h0, rd);
            k++;
        end while (rd[1] !== 1'h1 && k < 40);
        check(rd, 32'h2);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_SIG_HIGH, 32'h0, 1'h0, hi);
        bus(1'h1, 1'h0, 1'h1, SIZE_WORD, OFF_SIG_LOW, 32'h0, 1'h0, rd);
        s = {hi[15:0], rd[15:0]};
    endtask

    // The signature must repeat for unchanged contents and move when one word changes.
    task automatic t_sig;
        scan(s1);
        scan(s2);
        check(s2, s1);
        bus(1'h0, 1'h1, 1'h1, SIZE_WORD, {4'h5, 2'h0}, ~shadow[5], 1'h0, rd);
        scan(s3);
        check({31'h0, s3 === s1}, 32'h0);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out;
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_reset;
        t_ctrl;
        t_array;
        t_fetch;
        t_sig;
        close_out;
    end
endmodule // testbench

// ### hw/dpmr_pkg.sv
// Package with constants shared by the dual-port microcode RAM files.
package dpmr_pkg;
    // Control block spans 64 bytes; byte offsets of its registers.
    localparam int unsigned CTRL_ADDR_W = 6;
    localparam logic [5:0] OFF_CONFIG = 6'h00;
    localparam logic [5:0] OFF_BASE = 6'h04;
    localparam logic [5:0] OFF_SIG_HIGH = 6'h08;
    localparam logic [5:0] OFF_SIG_LOW = 6'h0C;
    localparam logic [5:0] OFF_SIG_COUNT = 6'h10;
    localparam logic [5:0] OFF_TEST_CTRL = 6'h14;
    // Writable bits of each register; other bits of CONFIG and BASE read as zero.
    localparam logic [31:0] MASK_CONFIG = 32'h0000_0001;
    localparam logic [31:0] MASK_BASE = 32'hFFFF_F001;
    localparam logic [31:0] MASK_TEST_CTRL = 32'h0000_0001;
    // Field positions.
    localparam int unsigned BIT_CFG_STOP = 0;
    localparam int unsigned BIT_BASE_EN = 0;
    localparam int unsigned BIT_TEST_START = 0;
    localparam int unsigned BIT_TEST_DONE = 1;
    // Reset values.
    localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
    localparam logic [31:0] RST_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_SIG = 32'h0000_0000;
    // Access sizes.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // Signature feedback taps.
    localparam logic [31:0] SIG_TAPS = 32'h8020_0003;
    // Array depth in 32-bit words.
    localparam int unsigned ARRAY_DEPTH = 1024;
endpackage

// ### hw/dpmr_sig.sv
// Signature engine that walks the array and folds every word into a MISR.
`timescale 1ns/100ps
module dpmr_sig #(
    parameter int unsigned DEPTH = dpmr_pkg::ARRAY_DEPTH,
    parameter int unsigned AW = $clog2(dpmr_pkg::ARRAY_DEPTH)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic start,
    output logic busy,
    output logic done,
    // Array read
    output logic [AW-1:0] scan_index,
    input wire logic [31:0] scan_word,
    // Result
    output logic [31:0] signature,
    output logic [AW-1:0] count
);
    import dpmr_pkg::*;

    typedef enum logic [1:0] {
        DPMR_SIG_IDLE = 2'b00,
        DPMR_SIG_RUN = 2'b01,
        DPMR_SIG_DONE = 2'b10
    } dpmr_sig_e;

    dpmr_sig_e state_ff;
    logic [31:0] sig_ff;
    logic [AW-1:0] idx_ff;
    logic [31:0] nxt_sig;

    assign nxt_sig = ({sig_ff[30:0], ^(sig_ff & SIG_TAPS)}) ^ scan_word;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= DPMR_SIG_IDLE;
        end else begin
            unique case (state_ff)
                DPMR_SIG_IDLE, DPMR_SIG_DONE: begin
                    if (start) begin
                        state_ff <= DPMR_SIG_RUN;
                    end
                end
                DPMR_SIG_RUN: begin
                    if (idx_ff == AW'(DEPTH - 1)) begin
                        state_ff <= DPMR_SIG_DONE;
                    end
                end
                default: state_ff <= DPMR_SIG_IDLE;
            endcase
        end
    end

    // The signature is cleared at start, so a rerun gives the same answer for the same contents.
    always_ff @(posedge clk) begin
        if (reset) begin
            sig_ff <= RST_SIG;
            idx_ff <= '0;
        end else if (state_ff != DPMR_SIG_RUN && start) begin
            sig_ff <= RST_SIG;
            idx_ff <= '0;
        end else if (state_ff == DPMR_SIG_RUN) begin
            sig_ff <= nxt_sig;
            idx_ff <= idx_ff + AW'(1);
        end
    end

    assign busy = (state_ff == DPMR_SIG_RUN);
    assign done = (state_ff == DPMR_SIG_DONE);
    assign scan_index = idx_ff;
    assign signature = sig_ff;
    assign count = idx_ff;
endmodule // dpmr_sig

// ### hw/dpmr_top.sv
// Dual-port microcode RAM: bus slave, two microcode read ports and signature check.
`timescale 1ns/100ps
module dpmr_top #(
    parameter int unsigned DEPTH = dpmr_pkg::ARRAY_DEPTH,
    parameter int unsigned AW = $clog2(dpmr_pkg::ARRAY_DEPTH)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Internal peripheral bus slave
    input wire logic bus_req,
    input wire logic bus_ctrl_sel,
    input wire logic bus_array_sel,
    input wire logic bus_wr,
    input wire logic bus_super,
    input wire logic [1:0] bus_size,
    input wire logic [AW+1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_ack,
    output logic bus_err,
    // Microcode mode from the time processor units
    input wire logic ucode_mode,
    // Time processor unit read port A
    input wire logic tpu_a_req,
    input wire logic [AW-1:0] tpu_a_addr,
    output logic [31:0] tpu_a_data,
    // Time processor unit read port B
    input wire logic tpu_b_req,
    input wire logic [AW-1:0] tpu_b_addr,
    output logic [31:0] tpu_b_data
);
    import dpmr_pkg::*;

    logic [31:0] mem_ff [DEPTH];
    logic [31:0] cfg_ff;
    logic [31:0] base_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] tpu_a_ff;
    logic [31:0] tpu_b_ff;
    logic scan_start_ff;
    logic scan_busy;
    logic scan_done;
    logic [AW-1:0] scan_index;
    logic [31:0] signature;
    logic [AW-1:0] scan_count;
    logic [AW:0] scan_run_ff;

    logic idle;
    logic tpu_any;
    logic take_ctrl;
    logic take_array;
    logic take_err;
    logic array_ok;
    logic [AW-1:0] word_idx;
    logic [1:0] lane;
    logic [3:0] byte_en;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [31:0] ctrl_rd;
    logic [5:0] ctrl_off;

    assign idle = !ack_ff && !err_ff;
    assign tpu_any = tpu_a_req || tpu_b_req;
    assign ctrl_off = bus_addr[5:0];
    assign word_idx = bus_addr[AW+1:2];
    assign lane = bus_addr[1:0];
    // While microcode runs from the array the base enable has no say over array access.
    assign array_ok = ucode_mode || (base_ff[BIT_BASE_EN] && !cfg_ff[BIT_CFG_STOP]);
    assign take_ctrl = idle && bus_req && bus_ctrl_sel && bus_super;
    // A bus cycle to the array waits while any microcode fetch is pending.
    assign take_array = idle && bus_req && bus_array_sel && !tpu_any && array_ok;
    assign take_err = idle && bus_req && ((bus_ctrl_sel && !bus_super) || (bus_array_sel && !array_ok));

    // Byte lanes for the three access sizes; a half-word uses address bit 1 only.
    always_comb begin
        unique case (bus_size)
            SIZE_BYTE: byte_en = 4'h1 << lane;
            SIZE_HALF: byte_en = lane[1] ? 4'hC : 4'h3;
            default: byte_en = 4'hF;
        endcase
    end

    always_comb begin
        wr_word = mem_ff[word_idx];
        for (int i = 0; i < 4; i++) begin
            if (byte_en[i]) begin
                wr_word[8*i +: 8] = bus_wdata[8*i +: 8];
            end
        end
    end

    // Read data is right-justified so narrow reads land in the low bits.
    always_comb begin
        unique case (bus_size)
            SIZE_BYTE: rd_word = {24'h00_0000, mem_ff[word_idx][8*lane +: 8]};
            SIZE_HALF: rd_word = {16'h0000, mem_ff[word_idx][16*lane[1] +: 16]};
            default: rd_word = mem_ff[word_idx];
        endcase
    end

    always_comb begin
        unique case (ctrl_off)
            OFF_CONFIG: ctrl_rd = cfg_ff & MASK_CONFIG;
            OFF_BASE: ctrl_rd = base_ff & MASK_BASE;
            OFF_SIG_HIGH: ctrl_rd = {16'h0000, signature[31:16]};
            OFF_SIG_LOW: ctrl_rd = {16'h0000, signature[15:0]};
            OFF_SIG_COUNT: ctrl_rd = 32'(scan_count);
            OFF_TEST_CTRL: ctrl_rd = {30'h0000_0000, scan_done, scan_busy};
            default: ctrl_rd = 32'h0000_0000;
        endcase
    end

    // Array storage; only the bus writes it, and only when no fetch is pending.
    always_ff @(posedge clk) begin
        if (take_array && bus_wr) begin
            mem_ff[word_idx] <= wr_word;
        end
    end

    // Each fetch port reads in every cycle it requests and never waits on the bus.
    always_ff @(posedge clk) begin
        if (reset) begin
            tpu_a_ff <= 32'h0000_0000;
            tpu_b_ff <= 32'h0000_0000;
        end else begin
            if (tpu_a_req) begin
                tpu_a_ff <= mem_ff[tpu_a_addr];
            end
            if (tpu_b_req) begin
                tpu_b_ff <= mem_ff[tpu_b_addr];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_ff <= RST_CONFIG;
            base_ff <= RST_BASE;
        end else if (take_ctrl && bus_wr) begin
            if (ctrl_off == OFF_CONFIG) begin
                cfg_ff <= bus_wdata & MASK_CONFIG;
            end
            if (ctrl_off == OFF_BASE) begin
                base_ff <= bus_wdata & MASK_BASE;
            end
        end
    end

    // A start request is dropped while microcode is running from the array.
    always_ff @(posedge clk) begin
        if (reset) begin
            scan_start_ff <= 1'b0;
        end else begin
            scan_start_ff <= take_ctrl && bus_wr && ctrl_off == OFF_TEST_CTRL
                && bus_wdata[BIT_TEST_START] && !ucode_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= take_ctrl || take_array;
            err_ff <= take_err;
            if (take_ctrl && !bus_wr) begin
                rdata_ff <= ctrl_rd;
            end else if (take_array && !bus_wr) begin
                rdata_ff <= rd_word;
            end else if (take_ctrl || take_array || take_err) begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    dpmr_sig #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_sig (
        .clk(clk),
        .reset(reset),
        .start(scan_start_ff && !ucode_mode),
        .busy(scan_busy),
        .done(scan_done),
        .scan_index(scan_index),
        .scan_word(mem_ff[scan_index]),
        .signature(signature),
        .count(scan_count)
    );

    assign bus_ack = ack_ff;
    assign bus_err = err_ff;
    assign bus_rdata = rdata_ff;
    assign tpu_a_data = tpu_a_ff;
    assign tpu_b_data = tpu_b_ff;

    // Busy cycles are counted here because a full-size array scan outlasts any practical delay range.
    always_ff @(posedge clk) begin
        if (reset) begin
            scan_run_ff <= '0;
        end else begin
            scan_run_ff <= scan_busy ? scan_run_ff + (AW+1)'(1) : '0;
        end
    end

    sequence user_ctrl_s;
        idle && bus_req && bus_ctrl_sel && !bus_super;
    endsequence

    sequence super_ctrl_s;
        idle && bus_req && bus_ctrl_sel && bus_super;
    endsequence

    user_error_a: assert property (@(posedge clk) disable iff (reset)
        user_ctrl_s |=> bus_err && !bus_ack) else $error("user control access not refused");
    super_ack_a: assert property (@(posedge clk) disable iff (reset)
        super_ctrl_s |=> bus_ack && !bus_err) else $error("supervisor control access not answered");
    unmapped_zero_a: assert property (@(posedge clk) disable iff (reset)
        super_ctrl_s and (!bus_wr && ctrl_off == 6'h3C) |=> bus_rdata == 32'h0000_0000)
        else $error("unmapped control read not zero");
    cfg_bits_a: assert property (@(posedge clk) disable iff (reset)
        (cfg_ff & ~MASK_CONFIG) == 32'h0000_0000 && (base_ff & ~MASK_BASE) == 32'h0000_0000)
        else $error("unimplemented register bit set");
    fetch_a_a: assert property (@(posedge clk) disable iff (reset)
        tpu_a_req && !(take_array && bus_wr) |=> tpu_a_data == $past(mem_ff[tpu_a_addr]))
        else $error("port A fetch data wrong");
    fetch_b_a: assert property (@(posedge clk) disable iff (reset)
        tpu_b_req && !(take_array && bus_wr) |=> tpu_b_data == $past(mem_ff[tpu_b_addr]))
        else $error("port B fetch data wrong");
    fetch_priority_a: assert property (@(posedge clk) disable iff (reset)
        tpu_any |=> !bus_ack || $past(bus_ctrl_sel)) else $error("bus array cycle during fetch");
    scan_ignored_a: assert property (@(posedge clk) disable iff (reset)
        ucode_mode && !scan_busy |=> !scan_busy) else $error("scan started in microcode mode");
    byte_write_a: assert property (@(posedge clk) disable iff (reset)
        take_array && bus_wr && bus_size == SIZE_BYTE && lane == 2'h0 ##1 !(take_array && bus_wr)
        |-> mem_ff[$past(word_idx)][31:8] == $past(mem_ff[word_idx][31:8]))
        else $error("byte write disturbed other lanes");
    scan_length_a: assert property (@(posedge clk) disable iff (reset)
        scan_busy |-> scan_run_ff < (AW+1)'(DEPTH)) else $error("scan did not finish");
    scan_end_a: assert property (@(posedge clk) disable iff (reset)
        scan_run_ff == (AW+1)'(DEPTH) |-> scan_done) else $error("scan end not flagged");
endmodule // dpmr_top
